// [hw/thermal_core_sensor.v]
// One core's digital temperature readout, trip and thresholds.
// Assumes temp is an absolute reading synchronous to clk.
`include "thermal_throttle_regs.vh"

module thermal_core_sensor (
    input  wire       clk,
    input  wire       srst,
    input  wire [7:0] temp,
    input  wire [7:0] thrA,
    input  wire [7:0] thrB,
    input  wire [1:0] thrEn,
    output reg  [6:0] readout,
    output reg        trip,
    output reg        cat,
    output reg  [1:0] crossed
);

// ----------------------------------------------------------
// Comparisons
// ----------------------------------------------------------
reg  [1:0] above_q;
wire [7:0] margin = `TJ_MAX - temp;
wire       atMax  = (temp >= `TJ_MAX);
wire [1:0] above_d = {temp >= thrB, temp >= thrA};

// Readout clamps at zero: never reports above the maximum
always @(posedge clk) begin
    if (srst) begin
        readout <= 7'h00;
        trip    <= 1'b0;
        cat     <= 1'b0;
        above_q <= 2'h0;
        crossed <= 2'h0;
    end else begin
        readout <= atMax ? 7'h00 : margin[6:0]; // RQ15
        // Hysteresis keeps the trip from chattering near max
        if (atMax)
            trip <= 1'b1; // RQ17
        else if (temp <= `TJ_MAX - `TJ_HYST)
            trip <= 1'b0; // RQ24
        cat     <= (temp >= `TJ_CAT);
        above_q <= above_d;
        crossed <= thrEn & (above_d ^ above_q); // RQ18
    end
end

endmodule

// [hw/thermal_throttle_control.v]
// Thermal throttle controller for a dual-core processor.
// Assumes Wishbone classic master, inputs synchronous to clk,
// and an external pull-up on the open-drain hot pin.
//
// Function
// RQ1: both auto modes: perf-state throttle wins
// RQ2: force option adds clock modulation if needed
// RQ3: faster software request deferred during throttle
// RQ4: slower software request taken immediately
// RQ5: on-demand enable bit throttles regardless of temperature
// RQ6: on-demand duty in eighths, one to seven
// RQ7: automatic modulation fixed at half duty
// RQ8: automatic behaviour beats on-demand when hot
// RQ9: drive hot pin low above trip point
// RQ10: optional interrupt on hot assert, deassert
// RQ11: no new hot assertion in low power
// RQ12: held hot stays until exit and cool; the code releases it once both cores cool, even while still in low power
// RQ13: hot released during deep power-down state
// RQ14: catastrophic trip asserts and stops clocks
// RQ15: readout relative, clamped at maximum
// RQ16: persistent heat latches out-of-spec plus sticky
// RQ17: throttle triggers at readout maximum
// RQ18: two threshold interrupts per core
// RQ19: external hot pull-low activates throttling
// RQ20: either core trips one pin, both modulated
// RQ21: any trip moves both cores to floor
// RQ22: external hot ignores force, perf only
// RQ23: throttle to floor, return to request
// RQ24: modulation stops once cool, with hysteresis
// RQ25: hot pin open-drain, wired-OR with outside
`include "thermal_throttle_regs.vh"

module thermal_throttle_control (
    input  wire        clk,
    input  wire        srst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [4:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [7:0]  core0Temp,
    input  wire [7:0]  core1Temp,
    input  wire        lowPowerState,
    input  wire        deepPowerDown,
    input  wire        hotIndicatorNIn,
    output reg         hotIndicatorNOut,
    output reg         hotIndicatorNOe,
    output reg         catastrophicTripN,
    output reg         coreClkRun,
    output reg  [3:0]  perfPoint,
    output reg         thermIrq,
    output reg  [1:0]  coreIrq
);

// ----------------------------------------------------------
// Byte-lane merge for register writes
// ----------------------------------------------------------
function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    integer i;
    begin
        merge = old;
        for (i = 0; i < 4; i = i + 1) begin
            if (sel[i])
                merge[i*8 +: 8] = dat[i*8 +: 8];
        end
    end
endfunction

// ----------------------------------------------------------
// State
// ----------------------------------------------------------
reg  [4:0]  ctrl_q;
reg  [4:0]  odCtl_q;
reg  [3:0]  swReq_q;
reg  [3:0]  floor_q;
reg  [17:0] thr0_q;
reg  [17:0] thr1_q;
reg         oos_q;
reg         oosSticky_q;
reg         hotAsEv_q;
reg         hotDeEv_q;
reg  [1:0]  thrEv0_q;
reg  [1:0]  thrEv1_q;
reg         pinLow_q;
reg         catLatched_q;
reg  [9:0]  hotCnt_q;
reg  [3:0]  stepCnt_q;
reg  [2:0]  phase_q;
reg         deferred_q;
reg  [31:0] rdData;
reg         hotDrive_d;
reg  [3:0]  perfPoint_d;
reg  [2:0]  onEighths;
reg         runGate;

wire [6:0] readout0;
wire [6:0] readout1;
wire       trip0;
wire       trip1;
wire       cat0;
wire       cat1;
wire [1:0] cross0;
wire [1:0] cross1;

// ----------------------------------------------------------
// Per-core sensors
// ----------------------------------------------------------
thermal_core_sensor sensor0 (
    .clk     (clk),
    .srst    (srst),
    .temp    (core0Temp),
    .thrA    (thr0_q[7:0]),
    .thrB    (thr0_q[15:8]),
    .thrEn   (thr0_q[17:16]),
    .readout (readout0),
    .trip    (trip0),
    .cat     (cat0),
    .crossed (cross0)
);

thermal_core_sensor sensor1 (
    .clk     (clk),
    .srst    (srst),
    .temp    (core1Temp),
    .thrA    (thr1_q[7:0]),
    .thrB    (thr1_q[15:8]),
    .thrEn   (thr1_q[17:16]),
    .readout (readout1),
    .trip    (trip1),
    .cat     (cat1),
    .crossed (cross1)
);

// ----------------------------------------------------------
// Throttle decision
// ----------------------------------------------------------
wire anyTrip = trip0 | trip1; // RQ20
// Only seen while we are not pulling the pin ourselves
wire extHot  = ~hotIndicatorNIn & ~hotIndicatorNOe; // RQ19
wire clkEn   = ctrl_q[`CTRL_CLKMOD_EN];
wire perfEn  = ctrl_q[`CTRL_PERF_EN];
wire autoEn  = clkEn | perfEn;
wire autoHot = autoEn & (anyTrip | extHot); // RQ19
wire odEn    = odCtl_q[`OD_EN];
wire [2:0] odDuty = odCtl_q[`OD_DUTY_MSB:`OD_DUTY_LSB];
wire perfThrottle = perfEn & autoHot; // RQ21
wire forceMod = ctrl_q[`CTRL_FORCE_MOD] & anyTrip & ~extHot
              & (hotCnt_q >= `FORCE_WAIT_CYC); // RQ22
// Perf throttle takes precedence unless force adds modulation
wire autoMod  = autoHot & clkEn & (~perfEn | forceMod); // RQ1 RQ2
wire odMod    = odEn & ~autoHot; // RQ8
wire tccActive = autoHot | odEn; // RQ5
wire busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wrReq    = busReq & wb_we_i;

// Duty select: auto duty cannot be changed by software
always @* begin
    if (autoMod)
        onEighths = `AUTO_DUTY; // RQ7
    else if (odDuty == 3'h0)
        onEighths = `AUTO_DUTY;
    else
        onEighths = odDuty; // RQ6
    if (autoMod | odMod)
        runGate = (phase_q < onEighths); // RQ20
    else
        runGate = 1'b1; // RQ24
end

// Operating point: floor while throttled if the request is above it, request otherwise
always @* begin
    if (perfThrottle && swReq_q > floor_q)
        perfPoint_d = floor_q; // RQ3
    else
        perfPoint_d = swReq_q; // RQ4 RQ23
end

// Hot pin drive across the power states
always @* begin
    if (deepPowerDown)
        hotDrive_d = 1'b0; // RQ13
    else if (lowPowerState)
        hotDrive_d = hotIndicatorNOe & anyTrip; // RQ11 RQ12
    else
        hotDrive_d = anyTrip; // RQ9
end

// ----------------------------------------------------------
// Modulation phase and persistence counter
// ----------------------------------------------------------
always @(posedge clk) begin
    if (srst) begin
        stepCnt_q <= 4'h0;
        phase_q   <= 3'h0;
        hotCnt_q  <= 10'h000;
    end else begin
        if (stepCnt_q == `MOD_STEP_CYC - 1) begin
            stepCnt_q <= 4'h0;
            phase_q   <= phase_q + 3'h1;
        end else begin
            stepCnt_q <= stepCnt_q + 4'h1;
        end
        // Counts how long heat persists under auto throttling
        if (!(autoHot && anyTrip))
            hotCnt_q <= 10'h000;
        else if (hotCnt_q != 10'h3FF)
            hotCnt_q <= hotCnt_q + 10'h001;
    end
end

// ----------------------------------------------------------
// Outputs toward the cores and the pins
// ----------------------------------------------------------
always @(posedge clk) begin
    if (srst) begin
        hotIndicatorNOut  <= 1'b0;
        hotIndicatorNOe   <= 1'b0;
        catLatched_q      <= 1'b0;
        catastrophicTripN <= 1'b1;
        coreClkRun        <= 1'b1;
        perfPoint         <= `SWREQ_RESET;
        deferred_q        <= 1'b0;
        pinLow_q          <= 1'b0;
        oos_q             <= 1'b0;
        thermIrq          <= 1'b0;
        coreIrq           <= 2'h0;
    end else begin
        // Open drain: only ever drives low
        hotIndicatorNOut <= 1'b0; // RQ25
        hotIndicatorNOe  <= hotDrive_d; // RQ25
        // Latched until reset: supply is expected to be cut
        if (cat0 | cat1)
            catLatched_q <= 1'b1; // RQ14
        catastrophicTripN <= ~(catLatched_q | cat0 | cat1); // RQ14
        coreClkRun <= runGate & ~catLatched_q & ~cat0 & ~cat1; // RQ14
        perfPoint  <= perfPoint_d; // RQ21
        deferred_q <= perfThrottle & (swReq_q > floor_q); // RQ3
        pinLow_q   <= ~hotIndicatorNIn;
        oos_q      <= autoHot & anyTrip
                    & (hotCnt_q >= `OOS_WAIT_CYC); // RQ16
        thermIrq <= (hotAsEv_q & ctrl_q[`CTRL_IRQ_ASSERT])
                  | (hotDeEv_q & ctrl_q[`CTRL_IRQ_DEASSERT])
                  | oosSticky_q; // RQ10 RQ16
        coreIrq  <= {|thrEv1_q, |thrEv0_q}; // RQ18
    end
end

// ----------------------------------------------------------
// Read multiplexer
// ----------------------------------------------------------
always @* begin
    case (wb_adr_i)
        `OFS_CTRL:     rdData = {27'h000_0000, ctrl_q};
        `OFS_ONDEMAND: rdData = {27'h000_0000, odCtl_q};
        `OFS_PERF:     rdData = {24'h00_0000, floor_q, swReq_q};
        `OFS_STATUS:   rdData = {20'h0_0000, perfPoint, deferred_q,
                                 extHot, hotDeEv_q, hotAsEv_q,
                                 oosSticky_q, oos_q, tccActive,
                                 pinLow_q};
        `OFS_DTS0:     rdData = {22'h00_0000, thrEv0_q, trip0,
                                 readout0};
        `OFS_DTS1:     rdData = {22'h00_0000, thrEv1_q, trip1,
                                 readout1};
        `OFS_THR0:     rdData = {14'h0000, thr0_q};
        `OFS_THR1:     rdData = {14'h0000, thr1_q};
        default:       rdData = 32'h0000_0000;
    endcase
end

// ----------------------------------------------------------
// Wishbone slave: one wait state, unmapped reads give zero
// ----------------------------------------------------------
wire [31:0] wrCtrl  = merge({27'h000_0000, ctrl_q},
                            wb_dat_i, wb_sel_i);
wire [31:0] wrOd    = merge({27'h000_0000, odCtl_q},
                            wb_dat_i, wb_sel_i);
wire [31:0] wrPerf  = merge({24'h00_0000, floor_q, swReq_q},
                            wb_dat_i, wb_sel_i);
wire [31:0] wrThr0  = merge({14'h0000, thr0_q},
                            wb_dat_i, wb_sel_i);
wire [31:0] wrThr1  = merge({14'h0000, thr1_q},
                            wb_dat_i, wb_sel_i);
wire [2:0]  clrSt   = (wrReq && wb_adr_i == `OFS_STATUS && wb_sel_i[0])
                    ? wb_dat_i[`ST_HOT_DEASSERT:`ST_OOS_STICKY] : 3'h0;
wire [1:0]  clrEv0  = (wrReq && wb_adr_i == `OFS_DTS0 && wb_sel_i[1])
                    ? wb_dat_i[`DTS_EV_LSB +: 2] : 2'h0;
wire [1:0]  clrEv1  = (wrReq && wb_adr_i == `OFS_DTS1 && wb_sel_i[1])
                    ? wb_dat_i[`DTS_EV_LSB +: 2] : 2'h0;
wire        hotRise = ~hotIndicatorNIn & ~pinLow_q;
wire        hotFall = hotIndicatorNIn & pinLow_q;

// Register writes; sticky bits let a new event beat the clear
always @(posedge clk) begin
    if (srst) begin
        wb_ack_o    <= 1'b0;
        wb_dat_o    <= 32'h0000_0000;
        ctrl_q      <= `CTRL_RESET;
        odCtl_q     <= `OD_RESET;
        swReq_q     <= `SWREQ_RESET;
        floor_q     <= `FLOOR_RESET;
        thr0_q      <= `THR_RESET;
        thr1_q      <= `THR_RESET;
        oosSticky_q <= 1'b0;
        hotAsEv_q   <= 1'b0;
        hotDeEv_q   <= 1'b0;
        thrEv0_q    <= 2'h0;
        thrEv1_q    <= 2'h0;
    end else begin
        wb_ack_o <= busReq;
        if (busReq && !wb_we_i)
            wb_dat_o <= rdData;
        if (wrReq) begin
            case (wb_adr_i)
                `OFS_CTRL:     ctrl_q  <= wrCtrl[4:0];
                // Takes effect at once, whatever the temperature
                `OFS_ONDEMAND: odCtl_q <= {wrOd[4:1], 1'b0}; // RQ5
                `OFS_PERF: begin
                    swReq_q <= wrPerf[3:0]; // RQ3 RQ4
                    floor_q <= wrPerf[7:4];
                end
                `OFS_THR0:     thr0_q  <= wrThr0[17:0];
                `OFS_THR1:     thr1_q  <= wrThr1[17:0];
                default: ;
            endcase
        end
        oosSticky_q <= (oosSticky_q & ~clrSt[0]) | oos_q; // RQ16
        hotAsEv_q   <= (hotAsEv_q & ~clrSt[1]) | hotRise; // RQ10
        hotDeEv_q   <= (hotDeEv_q & ~clrSt[2]) | hotFall; // RQ10
        thrEv0_q    <= (thrEv0_q & ~clrEv0) | cross0; // RQ18
        thrEv1_q    <= (thrEv1_q & ~clrEv1) | cross1; // RQ18
    end
end

endmodule

// [hw/thermal_throttle_regs.vh]
// Register map, field positions, reset values and timing counts
// for the thermal throttle controller. Definitions only.
`ifndef THERMAL_THROTTLE_REGS_VH
`define THERMAL_THROTTLE_REGS_VH

// ----------------------------------------------------------
// Byte offsets on the Wishbone slave
// ----------------------------------------------------------
`define OFS_CTRL     5'h00
`define OFS_ONDEMAND 5'h04
`define OFS_PERF     5'h08
`define OFS_STATUS   5'h0C
`define OFS_DTS0     5'h10
`define OFS_DTS1     5'h14
`define OFS_THR0     5'h18
`define OFS_THR1     5'h1C

// ----------------------------------------------------------
// Field positions
// ----------------------------------------------------------
`define CTRL_CLKMOD_EN   0
`define CTRL_PERF_EN     1
`define CTRL_FORCE_MOD   2
`define CTRL_IRQ_ASSERT  3
`define CTRL_IRQ_DEASSERT 4
`define OD_EN            4
`define OD_DUTY_MSB      3
`define OD_DUTY_LSB      1
`define ST_OOS_STICKY    3
`define ST_HOT_ASSERT    4
`define ST_HOT_DEASSERT  5
`define DTS_EV_LSB       8

// ----------------------------------------------------------
// Reset values
// ----------------------------------------------------------
`define CTRL_RESET  5'h03
`define OD_RESET    5'h00
`define SWREQ_RESET 4'hF
`define FLOOR_RESET 4'h0
`define THR_RESET   18'h0_0000

// ----------------------------------------------------------
// Temperatures in degrees, duty and timing
// ----------------------------------------------------------
`define TJ_MAX      8'h64
`define TJ_HYST     8'h02
`define TJ_CAT      8'h7D
`define AUTO_DUTY   3'h4
`define CLK_NS      100
`define MOD_STEP_NS 800
`define MOD_STEP_CYC (`MOD_STEP_NS / `CLK_NS)
`define FORCE_WAIT_NS 10000
`define FORCE_WAIT_CYC ((`FORCE_WAIT_NS + `CLK_NS - 1) / `CLK_NS)
`define OOS_WAIT_NS 50000
`define OOS_WAIT_CYC ((`OOS_WAIT_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// [tb/hot_pin_monitor.sv]
// Platform monitor on the open-drain hot pin.
// Assumes a pull-up on the pin; each party only pulls low.
module hot_pin_monitor (
    input  wire  devOe,
    input  wire  extPull,
    output logic pinLevel
);
    timeunit 1ns;
    timeprecision 1ns;
    // Wired-OR of both pull-downs, pull-up level otherwise
    assign pinLevel = !(devOe || extPull);
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the thermal throttle controller.
// Assumes a 10 MHz clock and the register header on the path.
`include "thermal_throttle_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [3:0]  sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [7:0]  t0 = 8'h28;
    logic [7:0]  t1 = 8'h28;
    logic        lp = 1'b0;
    logic        dpd = 1'b0;
    logic        extPull = 1'b0;
    logic [31:0] rd;
    wire  [31:0] rdat;
    wire         ack, pin, oeOut, oe, catN, clkRun, tIrq;
    wire  [3:0]  perf;
    wire  [1:0]  cIrq;
    int          errCount = 0;
    int          comparisons = 0;

    thermal_throttle_control thermal_throttle_control_i (
        .clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .core0Temp(t0),
        .core1Temp(t1), .lowPowerState(lp), .deepPowerDown(dpd), .hotIndicatorNIn(pin),
        .hotIndicatorNOut(oeOut), .hotIndicatorNOe(oe), .catastrophicTripN(catN),
        .coreClkRun(clkRun), .perfPoint(perf), .thermIrq(tIrq), .coreIrq(cIrq));
    hot_pin_monitor hot_pin_monitor_i (.devOe(oe), .extPull(extPull), .pinLevel(pin));

    // ----------------------------------------------------------
    // Clock, watchdog and shared tasks
    // ----------------------------------------------------------
    always #50 clk = ~clk;

    // Whole run is about 1650 cycles; generous margin
    initial begin
        repeat (10000) @(posedge clk);
        errCount++;
        completeRun();
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Classic cycle; request held until ack is sampled, only the watchdog ends a lost ack
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        check("ackWait", n, 2);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask

    task automatic rdChk(input string name, input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, 4'hF);
        check(name, rd & m, e);
    endtask

    task automatic waitCyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic setTemp(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        t0 <= a;
        t1 <= b;
        waitCyc(4);
    endtask

    // Run cycles over one 64-cycle modulation period
    task automatic runCount(input int exp);
        int k;
        k = 0;
        repeat (64) begin
            @(posedge clk);
            k += int'(clkRun === 1'b1);
        end
        check("coreClkRun", k, exp);
    endtask

    task automatic completeRun();
        $display("Comparisons %0d, mismatches %0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    initial begin
        waitCyc(10);
        srst <= 1'b0;
        rdChk("ctrl", `OFS_CTRL, 32'hFFFF_FFFF, 32'h3);
        rdChk("perf", `OFS_PERF, 32'hFF, 32'hF);
        xfer(1'b1, `OFS_CTRL, 32'hFF00, 4'h2);
        rdChk("ctrlLane", `OFS_CTRL, 32'hFF, 32'h3);
        setTemp(8'h5A, 8'h5A);
        rdChk("dts0", `OFS_DTS0, 32'hFF, 32'hA);
        wr(`OFS_PERF, 32'h4F);
        setTemp(8'h5A, `TJ_MAX);
        check("pin", 32'(pin), 32'h0);
        check("floor", 32'(perf), 32'h4);
        runCount(64);
        rdChk("dts1", `OFS_DTS1, 32'hFF, 32'h80);
        wr(`OFS_PERF, 32'h4C);
        waitCyc(3);
        check("deferred", 32'(perf), 32'h4);
        wr(`OFS_PERF, 32'h42);
        waitCyc(3);
        check("slower", 32'(perf), 32'h2);
        setTemp(8'h5A, 8'h63);
        check("hyst", 32'(pin), 32'h0);
        setTemp(8'h5A, 8'h5A);
        check("cool", 32'(pin), 32'h1);
        check("back", 32'(perf), 32'h2);
        wr(`OFS_PERF, 32'h4F);
        wr(`OFS_CTRL, 32'h1);
        setTemp(`TJ_MAX, 8'h5A);
        runCount(32);
        check("noPerf", 32'(perf), 32'hF);
        wr(`OFS_ONDEMAND, 32'h12);
        runCount(32);
        wr(`OFS_CTRL, 32'h0);
        setTemp(8'h5A, 8'h5A);
        for (int d = 1; d < 8; d++) begin
            wr(`OFS_ONDEMAND, 32'h10 | 32'(d << 1));
            waitCyc(4);
            runCount(d * 8);
        end
        wr(`OFS_ONDEMAND, 32'h0);
        wr(`OFS_CTRL, 32'h7);
        extPull <= 1'b1;
        waitCyc(150);
        check("extPerf", 32'(perf), 32'h4);
        runCount(64);
        extPull <= 1'b0;
        wr(`OFS_CTRL, 32'hF);
        wr(`OFS_STATUS, 32'h30);
        setTemp(`TJ_MAX, 8'h5A);
        waitCyc(1);
        check("irqHot", 32'(tIrq), 32'h1);
        wr(`OFS_STATUS, 32'h10);
        waitCyc(2);
        check("irqClr", 32'(tIrq), 32'h0);
        waitCyc(120);
        runCount(32);
        waitCyc(400);
        rdChk("oos", `OFS_STATUS, 32'h8, 32'h8);
        check("oosIrq", 32'(tIrq), 32'h1);
        wr(`OFS_CTRL, 32'h13);
        setTemp(8'h28, 8'h28);
        wr(`OFS_STATUS, 32'h18);
        waitCyc(2);
        check("irqCool", 32'(tIrq), 32'h1);
        wr(`OFS_STATUS, 32'h38);
        wr(`OFS_THR0, 32'h0001_0032);
        wr(`OFS_DTS0, 32'h300);
        setTemp(8'h3C, 8'h28);
        check("thrIrq", 32'(cIrq), 32'h1);
        lp <= 1'b1;
        setTemp(`TJ_MAX, 8'h28);
        check("lpNoHot", 32'(pin), 32'h1);
        lp <= 1'b0;
        waitCyc(4);
        lp <= 1'b1;
        waitCyc(4);
        check("lpHeld", 32'(pin), 32'h0);
        dpd <= 1'b1;
        waitCyc(4);
        check("deepRel", 32'(pin), 32'h1);
        setTemp(`TJ_CAT, 8'h28);
        check("catN", 32'(catN), 32'h0);
        check("clkStop", 32'(clkRun), 32'h0);
        completeRun();
    end
endmodule

// [tb/thermal_throttle_asserts.sv]
// Checker on the thermal throttle controller top-level ports.
// Assumes the register header is on the include path.
`include "thermal_throttle_regs.vh"
module thermal_throttle_asserts (
    input wire        clk,
    input wire        srst,
    input wire        wb_we_i,
    input wire [4:0]  wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire [7:0]  core0Temp,
    input wire [7:0]  core1Temp,
    input wire        lowPowerState,
    input wire        deepPowerDown,
    input wire        hotIndicatorNOut,
    input wire        hotIndicatorNOe,
    input wire        catastrophicTripN,
    input wire        coreClkRun
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------
    // Conditions seen at the inputs
    // ----------------------------------------------------------
    wire hotNow  = (core0Temp >= `TJ_MAX) || (core1Temp >= `TJ_MAX);
    wire catNow  = (core0Temp >= `TJ_CAT) || (core1Temp >= `TJ_CAT);
    wire dtsRead = wb_ack_o && !wb_we_i && (wb_adr_i == `OFS_DTS0 || wb_adr_i == `OFS_DTS1);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Two samples needed: trip then pin register
    property p_hotOe; (hotNow && !lowPowerState && !deepPowerDown) [*2] |=> hotIndicatorNOe; endproperty
    property p_noNewHot; (lowPowerState && !hotIndicatorNOe) [*2] |=> !hotIndicatorNOe; endproperty
    property p_heldHot; (lowPowerState && !deepPowerDown && hotIndicatorNOe && hotNow) [*2] |=> hotIndicatorNOe; endproperty
    property p_deepRel; deepPowerDown [*2] |=> !hotIndicatorNOe; endproperty
    property p_catTrip; catNow |-> ##2 !catastrophicTripN; endproperty
    property p_catLatch; !catastrophicTripN |=> !catastrophicTripN; endproperty
    property p_catClk; !catastrophicTripN [*3] |-> !coreClkRun; endproperty
    property p_openDrain; hotIndicatorNOe |-> !hotIndicatorNOut; endproperty
    // Readout never above max; zero readout means tripped
    property p_dts; dtsRead |-> wb_dat_o[6:0] <= 7'h64 && (wb_dat_o[6:0] != 7'h00 || wb_dat_o[7]); endproperty
    a_hotOe: assert property (p_hotOe) else $error("hot pin not driven");
    a_noNewHot: assert property (p_noNewHot) else $error("hot driven in low power");
    a_heldHot: assert property (p_heldHot) else $error("held hot released");
    a_deepRel: assert property (p_deepRel) else $error("hot kept in deep power down");
    a_catTrip: assert property (p_catTrip) else $error("no catastrophic trip");
    a_catLatch: assert property (p_catLatch) else $error("catastrophic trip not held");
    a_catClk: assert property (p_catClk) else $error("clocks run after trip");
    a_openDrain: assert property (p_openDrain) else $error("hot pin driven high");
    a_dts: assert property (p_dts) else $error("bad readout");
    // Main scenarios reached
    c_hot: cover property (hotIndicatorNOe);
    c_cat: cover property (!catastrophicTripN);
    c_dts: cover property (dtsRead);
endmodule

bind thermal_throttle_control thermal_throttle_asserts thermal_throttle_asserts_i (
    .clk(clk), .srst(srst), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .core0Temp(core0Temp), .core1Temp(core1Temp), .lowPowerState(lowPowerState),
    .deepPowerDown(deepPowerDown), .hotIndicatorNOut(hotIndicatorNOut), .hotIndicatorNOe(hotIndicatorNOe),
    .catastrophicTripN(catastrophicTripN), .coreClkRun(coreClkRun));
